// ==== verilog/lcso_pkg.sv ====
`default_nettype none
package lcso_pkg;
   // operation selected by the issue stage
   typedef enum logic [2:0]
   {
      LCSO_KIND_FSUBS = 3'h0,
      LCSO_KIND_ICBI  = 3'h1,
      LCSO_KIND_ISYNC = 3'h2,
      LCSO_KIND_LBZ   = 3'h3,
      LCSO_KIND_LFD   = 3'h4
   } lcso_kind_t;

   // gray along idle -> mem -> update, and idle -> sync; idle -> fadd / icbi change more than one bit
   typedef enum logic [2:0]
   {
      LCSO_ST_IDLE = 3'h0,
      LCSO_ST_MEM  = 3'h1,
      LCSO_ST_UPD  = 3'h3,
      LCSO_ST_SYNC = 3'h2,
      LCSO_ST_FADD = 3'h6,
      LCSO_ST_ICBI = 3'h7
   } lcso_state_t;

   localparam int GPR_W      = 32;
   localparam int FPR_W      = 64;
   localparam int REGSEL_W   = 5;
   localparam int DISP_W     = 16;
   localparam int BYTE_W     = 8;
   localparam int CLASS_W    = 5;
   localparam int COND_W     = 4;
   localparam int FP_SIGN    = 63;

   // fp_status_control field positions
   localparam int FS_ANY_EXC  = 31;
   localparam int FS_ENA_EXC  = 30;
   localparam int FS_INVALID  = 29;
   localparam int FS_OVERFLOW = 28;
   localparam int FS_UNDERFLW = 27;
   localparam int FS_INEXACT  = 25;
   localparam int FS_SNAN_INV = 24;
   localparam int FS_ISI_INV  = 23;
   localparam int FS_ROUND_UP = 17;
   localparam int FS_INEX_NOW = 16;
   localparam int FS_CLASS_LO = 11;
   localparam int FS_INV_EN   = 7;
   localparam int FS_OVF_EN   = 6;
   localparam int FS_UNF_EN   = 5;
   localparam int FS_INX_EN   = 3;
   localparam logic [31:0] FS_RESET = 32'h0000_0000;

   // instruction cache geometry: set index taken from the effective address
   localparam int SET_LSB = 5;
   localparam int SET_W   = 7;

   // implementation options
   localparam logic UNIFIED_CACHE = 1'b0;
   localparam logic MP_CAPABLE    = 1'b1;
endpackage : lcso_pkg
`default_nettype wire

// ==== verilog/lcso_ea_gen.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcso_ea_gen
(
   input  wire logic [4:0]  base_field_in,
   input  wire logic [31:0] base_value_in,
   input  wire logic [31:0] index_value_in,
   input  wire logic [15:0] disp_in,
   input  wire logic        indexed_in,
   input  wire logic        update_in,
   output logic      [31:0] ea_out
);
   import lcso_pkg::*;

   logic [31:0] base_term;
   logic [31:0] offset_term;

   always_comb
   begin
      // zero replaces the base only for non-update forms
      base_term   = (!update_in && base_field_in == 5'h00) ? 32'h0000_0000 : base_value_in;
      offset_term = indexed_in ? index_value_in
                               : {{(GPR_W - DISP_W){disp_in[DISP_W-1]}}, disp_in};
      ea_out      = base_term + offset_term;
   end
endmodule : lcso_ea_gen
`default_nettype wire

// ==== verilog/lcso_exec.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcso_exec
(
   input  wire logic                 mclk_in,
   input  wire logic                 rst_in,
   // issue
   input  wire logic                 op_valid_in,
   input  wire lcso_pkg::lcso_kind_t op_kind_in,
   input  wire logic                 update_in,
   input  wire logic                 indexed_in,
   input  wire logic                 record_bit_in,
   input  wire logic [4:0]           target_in,
   input  wire logic [4:0]           base_gpr_in,
   input  wire logic [15:0]          disp_in,
   input  wire logic [31:0]          base_value_in,
   input  wire logic [31:0]          index_value_in,
   input  wire logic [63:0]          fp_source_a_in,
   input  wire logic [63:0]          fp_source_b_in,
   input  wire logic                 ctx_event_in,
   input  wire logic                 earlier_done_in,
   output logic                      issue_ready_out,
   output logic                      stall_out,
   output logic                      flush_out,
   output logic                      invalid_form_out,
   // shared adder
   output logic                      fp_add_req_out,
   output logic [63:0]               fp_add_a_out,
   output logic [63:0]               fp_add_b_out,
   input  wire logic                 fp_add_done_in,
   input  wire logic [63:0]          fp_add_result_in,
   input  wire logic [4:0]           fp_add_class_in,
   input  wire logic                 fp_add_rounded_in,
   input  wire logic                 fp_add_inexact_in,
   input  wire logic                 fp_add_overflow_in,
   input  wire logic                 fp_add_underflow_in,
   input  wire logic                 fp_add_snan_in,
   input  wire logic                 fp_add_isi_in,
   // status and condition
   input  wire logic                 fp_status_load_in,
   input  wire logic [31:0]          fp_status_data_in,
   output logic [31:0]               fp_status_control_out,
   output logic                      fp_condition_we_out,
   output logic [3:0]                fp_condition_field_out,
   // memory
   output logic                      mem_req_out,
   output logic                      mem_double_out,
   output logic [31:0]               mem_addr_out,
   input  wire logic                 mem_ack_in,
   input  wire logic [63:0]          mem_data_in,
   // translation and cache maintenance
   output logic                      xlate_req_out,
   output logic [31:0]               xlate_addr_out,
   input  wire logic                 xlate_done_in,
   input  wire logic                 xlate_fault_in,
   input  wire logic                 coherency_required_in,
   output logic                      access_fault_out,
   output logic                      icache_inval_out,
   output logic [6:0]                icache_set_out,
   output logic                      bcast_inval_out,
   output logic [31:0]               bcast_addr_out,
   // register write ports
   output logic                      gpr_we_out,
   output logic [4:0]                gpr_addr_out,
   output logic [31:0]               gpr_data_out,
   output logic                      fpr_we_out,
   output logic [4:0]                fpr_addr_out,
   output logic [63:0]               fpr_data_out
);
   import lcso_pkg::*;

   lcso_state_t state_reg;
   lcso_state_t state_next;
   logic [31:0] ea;
   logic [31:0] ea_reg;
   logic [4:0]  target_reg;
   logic [4:0]  base_reg;
   logic        update_reg;
   logic        double_reg;
   logic        record_reg;
   logic        form_bad;
   logic        issue;
   logic        inv_trap;
   logic [31:0] status_next;

   lcso_ea_gen u_ea
   (
      .base_field_in  (base_gpr_in),
      .base_value_in  (base_value_in),
      .index_value_in (index_value_in),
      .disp_in        (disp_in),
      .indexed_in     (indexed_in),
      .update_in      (update_in),
      .ea_out         (ea)
   );

   assign issue = op_valid_in && state_reg == LCSO_ST_IDLE;

   always_comb
   begin
      form_bad = 1'b0;
      if (update_in && op_kind_in == LCSO_KIND_LBZ)
         form_bad = (base_gpr_in == 5'h00) || (base_gpr_in == target_in);
      else if (update_in && op_kind_in == LCSO_KIND_LFD)
         form_bad = (base_gpr_in == 5'h00);
   end

   // invalid exception with its trap enabled suppresses the result
   assign inv_trap = (fp_add_snan_in || fp_add_isi_in) && fp_status_control_out[FS_INV_EN];

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         LCSO_ST_IDLE:
         begin
            if (ctx_event_in)
               state_next = LCSO_ST_SYNC;
            else if (op_valid_in && !form_bad)
            begin
               case (op_kind_in)
                  LCSO_KIND_FSUBS: state_next = LCSO_ST_FADD;
                  LCSO_KIND_ICBI:  state_next = LCSO_ST_ICBI;
                  LCSO_KIND_ISYNC: state_next = LCSO_ST_SYNC;
                  LCSO_KIND_LBZ:   state_next = LCSO_ST_MEM;
                  LCSO_KIND_LFD:   state_next = LCSO_ST_MEM;
                  default:         state_next = LCSO_ST_IDLE;
               endcase
            end
         end
         LCSO_ST_MEM:
            if (mem_ack_in)
               state_next = update_reg ? LCSO_ST_UPD : LCSO_ST_IDLE;
         LCSO_ST_UPD:
            state_next = LCSO_ST_IDLE;
         LCSO_ST_SYNC:
            if (earlier_done_in)
               state_next = LCSO_ST_IDLE;
         LCSO_ST_FADD:
            if (fp_add_done_in)
               state_next = LCSO_ST_IDLE;
         LCSO_ST_ICBI:
            if (xlate_done_in)
               state_next = LCSO_ST_IDLE;
         default:
            state_next = LCSO_ST_IDLE;
      endcase
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         state_reg <= LCSO_ST_IDLE;
      else
         state_reg <= state_next;
   end

   // issue-time capture
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ea_reg     <= 32'h0000_0000;
         target_reg <= 5'h00;
         base_reg   <= 5'h00;
         update_reg <= 1'b0;
         double_reg <= 1'b0;
         record_reg <= 1'b0;
      end
      else if (issue)
      begin
         ea_reg     <= ea;
         target_reg <= target_in;
         base_reg   <= base_gpr_in;
         update_reg <= update_in;
         double_reg <= (op_kind_in == LCSO_KIND_LFD);
         record_reg <= record_bit_in;
      end
   end

   // pipeline control: nothing later starts while busy
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         issue_ready_out  <= 1'b0;
         stall_out        <= 1'b0;
         flush_out        <= 1'b0;
         invalid_form_out <= 1'b0;
      end
      else
      begin
         issue_ready_out  <= (state_next == LCSO_ST_IDLE);
         stall_out        <= (state_next == LCSO_ST_SYNC);
         // flush only, no bus traffic from a synchronize
         flush_out        <= (state_reg == LCSO_ST_SYNC) && earlier_done_in;
         invalid_form_out <= issue && !ctx_event_in && form_bad;
      end
   end

   // memory access for loads
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mem_req_out    <= 1'b0;
         mem_double_out <= 1'b0;
         mem_addr_out   <= 32'h0000_0000;
      end
      else if (state_reg == LCSO_ST_IDLE && state_next == LCSO_ST_MEM)
      begin
         mem_req_out    <= 1'b1;
         mem_double_out <= (op_kind_in == LCSO_KIND_LFD);
         mem_addr_out   <= ea;
      end
      else if (mem_ack_in)
         mem_req_out <= 1'b0;
   end

   // general register writes: byte data, then base update
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         gpr_we_out   <= 1'b0;
         gpr_addr_out <= 5'h00;
         gpr_data_out <= 32'h0000_0000;
      end
      else if (state_reg == LCSO_ST_MEM && mem_ack_in && !double_reg)
      begin
         gpr_we_out   <= 1'b1;
         gpr_addr_out <= target_reg;
         gpr_data_out <= {{(GPR_W - BYTE_W){1'b0}}, mem_data_in[BYTE_W-1:0]};
      end
      else if (state_reg == LCSO_ST_UPD)
      begin
         gpr_we_out   <= 1'b1;
         gpr_addr_out <= base_reg;
         gpr_data_out <= ea_reg;
      end
      else
         gpr_we_out <= 1'b0;
   end

   // floating register writes: doubleword load or subtract result
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         fpr_we_out   <= 1'b0;
         fpr_addr_out <= 5'h00;
         fpr_data_out <= 64'h0000_0000_0000_0000;
      end
      else if (state_reg == LCSO_ST_MEM && mem_ack_in && double_reg)
      begin
         fpr_we_out   <= 1'b1;
         fpr_addr_out <= target_reg;
         fpr_data_out <= mem_data_in;
      end
      else if (state_reg == LCSO_ST_FADD && fp_add_done_in && !inv_trap)
      begin
         fpr_we_out   <= 1'b1;
         fpr_addr_out <= target_reg;
         fpr_data_out <= fp_add_result_in;
      end
      else
         fpr_we_out <= 1'b0;
   end

   // operands to the shared add unit
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         fp_add_req_out <= 1'b0;
         fp_add_a_out   <= 64'h0000_0000_0000_0000;
         fp_add_b_out   <= 64'h0000_0000_0000_0000;
      end
      else if (state_reg == LCSO_ST_IDLE && state_next == LCSO_ST_FADD)
      begin
         fp_add_req_out <= 1'b1;
         fp_add_a_out   <= fp_source_a_in;
         fp_add_b_out   <= {~fp_source_b_in[FP_SIGN], fp_source_b_in[FP_SIGN-1:0]};
      end
      else if (fp_add_done_in)
         fp_add_req_out <= 1'b0;
   end

   // status update; a software load is overridden by same-cycle hardware sets
   always_comb
   begin
      status_next = fp_status_load_in ? fp_status_data_in : fp_status_control_out;
      if (state_reg == LCSO_ST_FADD && fp_add_done_in)
      begin
         status_next[FS_ROUND_UP] = fp_add_rounded_in;
         status_next[FS_INEX_NOW] = fp_add_inexact_in;
         status_next[FS_OVERFLOW] = status_next[FS_OVERFLOW] | fp_add_overflow_in;
         status_next[FS_UNDERFLW] = status_next[FS_UNDERFLW] | fp_add_underflow_in;
         status_next[FS_INEXACT]  = status_next[FS_INEXACT] | fp_add_inexact_in;
         status_next[FS_SNAN_INV] = status_next[FS_SNAN_INV] | fp_add_snan_in;
         status_next[FS_ISI_INV]  = status_next[FS_ISI_INV] | fp_add_isi_in;
         if (!inv_trap)
            status_next[FS_CLASS_LO +: CLASS_W] = fp_add_class_in;
         // summary: newly raised exception bit
         if ((fp_add_overflow_in && !fp_status_control_out[FS_OVERFLOW])
             || (fp_add_underflow_in && !fp_status_control_out[FS_UNDERFLW])
             || (fp_add_inexact_in && !fp_status_control_out[FS_INEXACT])
             || (fp_add_snan_in && !fp_status_control_out[FS_SNAN_INV])
             || (fp_add_isi_in && !fp_status_control_out[FS_ISI_INV]))
            status_next[FS_ANY_EXC] = 1'b1;
      end
      status_next[FS_INVALID] = status_next[FS_SNAN_INV] | status_next[FS_ISI_INV];
      status_next[FS_ENA_EXC] = (status_next[FS_INVALID] & status_next[FS_INV_EN])
                              | (status_next[FS_OVERFLOW] & status_next[FS_OVF_EN])
                              | (status_next[FS_UNDERFLW] & status_next[FS_UNF_EN])
                              | (status_next[FS_INEXACT] & status_next[FS_INX_EN]);
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         fp_status_control_out <= FS_RESET;
      else
         fp_status_control_out <= status_next;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         fp_condition_we_out    <= 1'b0;
         fp_condition_field_out <= 4'h0;
      end
      else if (state_reg == LCSO_ST_FADD && fp_add_done_in && record_reg)
      begin
         fp_condition_we_out    <= 1'b1;
         fp_condition_field_out <= {status_next[FS_ANY_EXC], status_next[FS_ENA_EXC],
                                    status_next[FS_INVALID], status_next[FS_OVERFLOW]};
      end
      else
         fp_condition_we_out <= 1'b0;
   end

   // block invalidation: translate as a byte load first
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         xlate_req_out  <= 1'b0;
         xlate_addr_out <= 32'h0000_0000;
      end
      else if (state_reg == LCSO_ST_IDLE && state_next == LCSO_ST_ICBI)
      begin
         xlate_req_out  <= 1'b1;
         xlate_addr_out <= ea;
      end
      else if (xlate_done_in)
         xlate_req_out <= 1'b0;
   end

   // cache attributes other than coherency are not looked at
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         access_fault_out <= 1'b0;
         icache_inval_out <= 1'b0;
         icache_set_out   <= 7'h00;
         bcast_inval_out  <= 1'b0;
         bcast_addr_out   <= 32'h0000_0000;
      end
      else if (state_reg == LCSO_ST_ICBI && xlate_done_in)
      begin
         access_fault_out <= xlate_fault_in;
         icache_inval_out <= !xlate_fault_in && !UNIFIED_CACHE;
         icache_set_out   <= ea_reg[SET_LSB +: SET_W];
         bcast_inval_out  <= !xlate_fault_in && coherency_required_in && MP_CAPABLE;
         bcast_addr_out   <= ea_reg;
      end
      else
      begin
         access_fault_out <= 1'b0;
         icache_inval_out <= 1'b0;
         bcast_inval_out  <= 1'b0;
      end
   end
endmodule : lcso_exec
`default_nettype wire

// ==== sim/lcso_far_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcso_far_model
(
   input  wire logic        mclk_in,
   input  wire logic        rst_in,
   input  wire logic [2:0]  req_in,
   input  wire logic [3:0]  delay_in,
   input  wire logic [63:0] data_in,
   output logic      [2:0]  done_out,
   output logic      [63:0] data_out
);
   logic [3:0] cnt_reg;
   logic       ans_reg;
   // one answer per delay count, then the count restarts while a request is held
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         ans_reg <= 1'b0;
      else
         ans_reg <= !ans_reg && (|req_in) && cnt_reg == delay_in;
   end
   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         cnt_reg <= 4'h0;
      else
         cnt_reg <= (ans_reg || !(|req_in)) ? 4'h0 : cnt_reg + 4'h1;
   end
   assign done_out = ans_reg ? req_in : 3'h0;
   // data only meaningful with the answer
   assign data_out = ans_reg ? data_in : ~data_in;
endmodule : lcso_far_model
`default_nettype wire

// ==== sim/lcso_exec_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcso_exec_sva
(
   input wire logic        mclk_in,
   input wire logic        rst_in,
   input wire logic        earlier_done_in,
   input wire logic        stall_out,
   input wire logic        flush_out,
   input wire logic        issue_ready_out,
   input wire logic        mem_double_out,
   input wire logic        mem_ack_in,
   input wire logic [63:0] mem_data_in,
   input wire logic        xlate_req_out,
   input wire logic        xlate_done_in,
   input wire logic        xlate_fault_in,
   input wire logic        coherency_required_in,
   input wire logic [31:0] xlate_addr_out,
   input wire logic        icache_inval_out,
   input wire logic [6:0]  icache_set_out,
   input wire logic        bcast_inval_out,
   input wire logic [31:0] gpr_data_out,
   input wire logic        gpr_we_out,
   input wire logic        fpr_we_out,
   input wire logic [63:0] fpr_data_out,
   input wire logic        fp_add_req_out,
   input wire logic [63:0] fp_add_b_out,
   input wire logic [63:0] fp_source_b_in
);
   logic [63:0] data_q;
   logic [6:0]  set_q;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (rst_in);
   always_ff @(posedge mclk_in)
   begin
      data_q <= mem_data_in;
      set_q  <= xlate_addr_out[11:5];
   end
   a_sub_sign_flip: assert property
      ($rose(fp_add_req_out) |-> fp_add_b_out == (fp_source_b_in ^ 64'h8000_0000_0000_0000))
      else $error("subtract operand sign not inverted");
   a_byte_zero_ext: assert property
      (mem_ack_in && !mem_double_out |=> gpr_we_out && gpr_data_out == {24'h0, data_q[7:0]})
      else $error("byte load not zero extended");
   a_double_intact: assert property
      (mem_ack_in && mem_double_out |=> fpr_we_out && fpr_data_out == data_q)
      else $error("double load data altered");
   a_sync_waits: assert property
      (stall_out && !earlier_done_in |=> !flush_out && stall_out)
      else $error("synchronize finished early");
   a_sync_flush: assert property
      (stall_out && earlier_done_in |=> flush_out && !stall_out && issue_ready_out)
      else $error("synchronize did not flush");
   a_sync_holds: assert property
      (stall_out |-> !issue_ready_out && !xlate_req_out && !bcast_inval_out && !icache_inval_out)
      else $error("activity during synchronize");
   a_inval_scope: assert property
      (xlate_req_out && xlate_done_in |=> icache_inval_out == !$past(xlate_fault_in)
       && bcast_inval_out == ($past(coherency_required_in) && !$past(xlate_fault_in)))
      else $error("invalidation scope wrong");
   a_set_index: assert property
      (icache_inval_out |-> icache_set_out == set_q)
      else $error("invalidation set index wrong");
   c_flush: cover property (flush_out);
   c_bcast: cover property (bcast_inval_out);
   c_fdbl: cover property (mem_ack_in && mem_double_out);
endmodule : lcso_exec_sva
bind lcso_exec lcso_exec_sva u_sva (.mclk_in, .rst_in, .earlier_done_in, .stall_out, .flush_out,
   .issue_ready_out, .mem_double_out, .mem_ack_in, .mem_data_in, .xlate_req_out, .xlate_done_in,
   .xlate_fault_in, .coherency_required_in, .xlate_addr_out, .icache_inval_out, .icache_set_out,
   .bcast_inval_out, .gpr_data_out, .gpr_we_out, .fpr_we_out, .fpr_data_out, .fp_add_req_out,
   .fp_add_b_out, .fp_source_b_in);
`default_nettype wire

// ==== sim/lcso_exec_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module lcso_exec_tb;
   import lcso_pkg::*;
   typedef struct {string name; logic [71:0] val;} lcso_note_t;
   logic mclk_in, rst_in, op_valid_in, update_in, indexed_in, record_bit_in, ctx_event_in, earlier_done_in;
   logic issue_ready_out, stall_out, flush_out, invalid_form_out, fp_add_req_out, fp_add_done_in;
   logic fp_add_rounded_in, fp_add_inexact_in, fp_add_overflow_in, fp_add_underflow_in, fp_add_snan_in;
   logic fp_add_isi_in, fp_status_load_in, fp_condition_we_out, mem_req_out, mem_double_out, mem_ack_in;
   logic xlate_req_out, xlate_done_in, xlate_fault_in, coherency_required_in, access_fault_out;
   logic icache_inval_out, bcast_inval_out, gpr_we_out, fpr_we_out, prev_add, prev_mem;
   logic [3:0]  fp_condition_field_out, far_delay;
   logic [4:0]  target_in, base_gpr_in, fp_add_class_in, gpr_addr_out, fpr_addr_out;
   logic [6:0]  icache_set_out;
   logic [15:0] disp_in;
   logic [31:0] base_value_in, index_value_in, fp_status_data_in, fp_status_control_out, mem_addr_out;
   logic [31:0] xlate_addr_out, bcast_addr_out, gpr_data_out, ea;
   logic [63:0] fp_source_a_in, fp_source_b_in, fp_add_a_out, fp_add_b_out, fp_add_result_in, mem_data_in;
   logic [63:0] fpr_data_out, far_data;
   lcso_kind_t  op_kind_in;
   lcso_note_t  notes[$];
   int          miscompares = 0, num_checks = 0, cycles = 0;
   // load table: fp, update, indexed, target, base
   localparam logic [12:0] LD [9] = '{13'h0060, 13'h0486, 13'h08e8, 13'h0d2a, 13'h1045, 13'h1d6b,
                                       13'h08a0, 13'h0d8c, 13'h1860};
   lcso_exec dut (.*);
   lcso_far_model far (.mclk_in(mclk_in), .rst_in(rst_in), .req_in({fp_add_req_out, xlate_req_out, mem_req_out}),
      .delay_in(far_delay), .data_in(far_data), .done_out({fp_add_done_in, xlate_done_in, mem_ack_in}),
      .data_out(mem_data_in));
   assign fp_add_result_in = fp_add_a_out ^ mem_data_in;
   always #50 mclk_in = ~mclk_in;
   task automatic check(string what, logic [71:0] seen, logic [71:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic note(string name, logic [71:0] val);
      notes.push_back('{name, val});
   endtask : note
   task automatic take(string name, logic [71:0] seen);
      lcso_note_t n;
      n = (notes.size() > 0) ? notes.pop_front() : '{"none", 72'h0};
      check(name, seen, (n.name == name) ? n.val : ~seen);
   endtask : take
   task automatic report_and_stop();
      if (notes.size() != 0)
         miscompares++;
      if (miscompares == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   // idle, or in a synchronize so that a held request can be tried
   task automatic wait_idle();
      do
         @(negedge mclk_in);
      while (issue_ready_out !== 1'b1 && stall_out !== 1'b1);
      @(posedge mclk_in);
   endtask : wait_idle
   task automatic issue(lcso_kind_t k, logic [12:0] f);
      wait_idle();
      op_kind_in <= k;
      {update_in, indexed_in, target_in, base_gpr_in} <= f[11:0];
      {base_value_in, index_value_in, disp_in} <= {$urandom, $urandom, 16'($urandom)};
      {fp_source_a_in, fp_source_b_in, far_data} <= {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
      far_delay <= 4'($urandom % 8);
      op_valid_in <= 1'b1;
      do
         @(negedge mclk_in);
      while (issue_ready_out !== 1'b1);
      @(posedge mclk_in);
      op_valid_in <= 1'b0;
      ea = ((f[4:0] == 5'h0 && !f[11]) ? 32'h0 : base_value_in) + (f[10] ? index_value_in : 32'(signed'(disp_in)));
   endtask : issue
   task automatic ld_case(logic [12:0] f);
      issue(f[12] ? LCSO_KIND_LFD : LCSO_KIND_LBZ, f);
      if (f[11] && (f[4:0] == 5'h0 || (!f[12] && f[4:0] == f[9:5])))
         note("inv", 72'h1);
      else
      begin
         note("addr", {40'h0, ea});
         if (f[12])
            note("fpr", {3'h0, f[9:5], far_data});
         else
            note("gpr", {35'h0, f[9:5], 24'h0, far_data[7:0]});
         if (f[11])
            note("gpr", {35'h0, f[4:0], ea});
      end
   endtask : ld_case
   task automatic sub_case(logic [4:0] cls, logic ovf, logic snan, logic [35:0] cond);
      wait_idle();
      {fp_add_class_in, fp_add_overflow_in, fp_add_snan_in, record_bit_in} <= {cls, ovf, snan, cond != 36'h0};
      issue(LCSO_KIND_FSUBS, 13'h00c0);
      note("add_b", {8'h0, fp_source_b_in ^ 64'h8000_0000_0000_0000});
      if (!snan)
         note("fpr", {3'h0, 5'h06, fp_source_a_in ^ far_data});
      if (cond != 36'h0)
         note("cond", {36'h0, cond});
   endtask : sub_case
   always @(negedge mclk_in)
   begin
      if (rst_in === 1'b0 && fp_add_req_out === 1'b1 && prev_add !== 1'b1)
         take("add_b", {8'h0, fp_add_b_out});
      if (rst_in === 1'b0 && mem_req_out === 1'b1 && prev_mem !== 1'b1)
         take("addr", {40'h0, mem_addr_out});
      {prev_add, prev_mem} = {fp_add_req_out, mem_req_out};
      if (gpr_we_out === 1'b1)
         take("gpr", {35'h0, gpr_addr_out, gpr_data_out});
      if (fpr_we_out === 1'b1)
         take("fpr", {3'h0, fpr_addr_out, fpr_data_out});
      if (fp_condition_we_out === 1'b1)
         take("cond", {36'h0, fp_condition_field_out, fp_status_control_out});
      if (invalid_form_out === 1'b1)
         take("inv", 72'h1);
      if (access_fault_out === 1'b1)
         take("fault", 72'h1);
      if (icache_inval_out === 1'b1)
         take("set", {65'h0, icache_set_out});
      if (bcast_inval_out === 1'b1)
         take("bcast", {40'h0, bcast_addr_out});
      if (flush_out === 1'b1)
         take("flush", 72'h1);
   end
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         miscompares++;
         report_and_stop();
      end
   end
   initial
   begin
      {mclk_in, rst_in, earlier_done_in, prev_add, prev_mem, far_data, far_delay} = {3'b011, 70'h0};
      {op_valid_in, update_in, indexed_in, record_bit_in, ctx_event_in, fp_status_load_in} = '0;
      {fp_add_rounded_in, fp_add_inexact_in, fp_add_overflow_in, fp_add_underflow_in} = '0;
      {fp_add_snan_in, fp_add_isi_in, xlate_fault_in, coherency_required_in, fp_add_class_in} = '0;
      {target_in, base_gpr_in, disp_in, base_value_in, index_value_in, fp_status_data_in} = '0;
      {fp_source_a_in, fp_source_b_in} = '0;
      op_kind_in = LCSO_KIND_FSUBS;
      void'($urandom(65));
      repeat (20) @(posedge mclk_in);
      rst_in <= 1'b0;
      repeat (2) @(posedge mclk_in);
      for (int i = 0; i < 9; i++)
         ld_case(LD[i]);
      sub_case(5'h04, 1'b0, 1'b0, 36'h0);
      sub_case(5'h09, 1'b1, 1'b0, {4'h9, 32'h9000_4800});
      wait_idle();
      {fp_status_data_in, fp_status_load_in} <= {32'h0000_0080, 1'b1};
      @(posedge mclk_in);
      fp_status_load_in <= 1'b0;
      sub_case(5'h11, 1'b0, 1'b1, {4'he, 32'he100_0080});
      for (int i = 0; i < 3; i++)
      begin
         wait_idle();
         {coherency_required_in, xlate_fault_in} <= {i == 0, i == 2};
         issue(LCSO_KIND_ICBI, (i == 1) ? 13'h0407 : 13'h0400);
         if (i == 2)
            note("fault", 72'h1);
         else
            note("set", {65'h0, ea[11:5]});
         if (i == 0)
            note("bcast", {40'h0, ea});
      end
      earlier_done_in <= 1'b0;
      issue(LCSO_KIND_ISYNC, 13'h0);
      note("flush", 72'h1);
      fork
         ld_case(LD[1]);
         begin
            repeat (8) @(posedge mclk_in);
            earlier_done_in <= 1'b1;
         end
      join
      wait_idle();
      {earlier_done_in, ctx_event_in} <= 2'b01;
      @(posedge mclk_in);
      ctx_event_in <= 1'b0;
      note("flush", 72'h1);
      repeat (5) @(posedge mclk_in);
      earlier_done_in <= 1'b1;
      wait_idle();
      repeat (3) @(posedge mclk_in);
      report_and_stop();
   end
endmodule : lcso_exec_tb
`default_nettype wire
